// *** hw/ocg_operate_unit.sv ***
// Operate-class decode and group-one execution unit with APB registers
`timescale 1ns/100ps
module ocg_operate_unit
  import ocg_pkg::*;
#(
  parameter int DIV = STATE_DIV
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core state
  output logic      [11:0]       work_register,
  output logic                   carry_flag,
  output logic                   busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  ocg_acc_s    acc;
  ocg_acc_s    step_acc;
  ocg_dec_s    dec;
  ocg_dec_s    wdec;
  ocg_fsm_e    fsm;
  logic [11:0] instr_q;
  logic [1:0]  step;
  logic [4:0]  state_cnt;
  logic [4:0]  states_q;
  logic        done;
  logic        refused;
  logic        tick;
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic        start;
  logic        finish;
  logic [31:0] rd_mux;
  logic [6:0]  status;

  // APB decode
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign wdec   = ocg_decode(pwdata[11:0]);
  assign start  = wr_acc & (paddr == OFS_INSTR) & ~busy & wdec.grp1;
  assign finish = (fsm == FSM_HOLD) & tick & (state_cnt == states_q - 5'h01);

  always_comb begin
    mapped = (paddr == OFS_INSTR) | (paddr == OFS_WORK) | (paddr == OFS_FLAG) |
             (paddr == OFS_STATUS) | (paddr == OFS_STATES);
  end

  always_comb begin
    status              = '0;
    status[STB_BUSY]    = busy;
    status[STB_DONE]    = done;
    status[STB_OPCLASS] = dec.operate_class;
    status[STB_G1]      = dec.grp1;
    status[STB_G2]      = dec.grp2;
    status[STB_G3]      = dec.grp3;
    status[STB_REFUSED] = refused;
  end

  always_comb begin
    case (paddr)
      OFS_INSTR:  rd_mux = {20'h00000, instr_q};
      OFS_WORK:   rd_mux = {20'h00000, acc.word};
      OFS_FLAG:   rd_mux = {31'h00000000, acc.flag};
      OFS_STATUS: rd_mux = {25'h0000000, status};
      OFS_STATES: rd_mux = {27'h0000000, states_q};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  // Zero-wait answer; read data is the snapshot taken at setup
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Instruction latch and group decode
  always_ff @(posedge mclk) begin
    if (srst) begin
      instr_q  <= RST_INSTR;
      dec      <= ocg_decode(RST_INSTR);
      states_q <= STATES_SHORT;
    end else if (wr_acc && (paddr == OFS_INSTR) && !busy) begin
      instr_q  <= pwdata[11:0];
      dec      <= wdec;
      states_q <= ((pwdata[11:0] & LONG_MASK) != 12'h000) ? STATES_LONG : STATES_SHORT;
    end
  end

  ocg_tick_div #(
    .DIV (DIV)
  ) u_div (
    .mclk (mclk),
    .srst (srst),
    .clr  (start),
    .tick (tick)
  );

  // One step of the selected sequence per state tick
  ocg_g1_step u_step (
    .sel     (instr_q[7:0]),
    .step    (step),
    .acc_in  (acc),
    .acc_out (step_acc)
  );

  // Sequencer: steps 1..4 in order, then hold out the state count
  always_ff @(posedge mclk) begin
    if (srst) begin
      fsm       <= FSM_IDLE;
      step      <= SEQ_FIRST;
      state_cnt <= 5'h00;
    end else begin
      case (fsm)
        FSM_IDLE: begin
          if (start) begin
            fsm       <= FSM_STEP;
            step      <= SEQ_FIRST;
            state_cnt <= 5'h00;
          end
        end
        FSM_STEP: begin
          if (tick) begin
            state_cnt <= state_cnt + 5'h01;
            step      <= step + 2'h1;
            if (step == SEQ_LAST) begin
              fsm <= FSM_HOLD;
            end
          end
        end
        FSM_HOLD: begin
          if (finish) begin
            fsm <= FSM_IDLE;
          end else if (tick) begin
            state_cnt <= state_cnt + 5'h01;
          end
        end
        default: begin
          fsm <= FSM_IDLE;
        end
      endcase
    end
  end

  // Work register and flag; software writes only while idle
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc.word <= RST_WORD;
      acc.flag <= RST_FLAG;
    end else if (fsm == FSM_STEP && tick) begin
      acc <= step_acc;
    end else if (wr_acc && !busy) begin
      if (paddr == OFS_WORK) acc.word <= pwdata[11:0];
      if (paddr == OFS_FLAG) acc.flag <= pwdata[0];
    end
  end

  // Status flags; start and refusal can never coincide
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      refused <= 1'b0;
    end else begin
      if (start) begin
        busy <= 1'b1;
      end else if (finish) begin
        busy <= 1'b0;
      end
      if (finish) begin
        done <= 1'b1;
      end else if (start) begin
        done <= 1'b0;
      end
      if (wr_acc && busy) begin
        refused <= 1'b1;
      end else if (start) begin
        refused <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      work_register <= RST_WORD;
      carry_flag    <= RST_FLAG;
    end else begin
      work_register <= acc.word;
      carry_flag    <= acc.flag;
    end
  end

  // Checking helpers
  logic [4:0]  run_ticks;
  logic [11:0] word_start;
  logic        flag_start;

  always_ff @(posedge mclk) begin
    if (srst) begin
      run_ticks  <= 5'h00;
      word_start <= RST_WORD;
      flag_start <= RST_FLAG;
    end else if (start) begin
      run_ticks  <= 5'h00;
      word_start <= acc.word;
      flag_start <= acc.flag;
    end else if (busy && tick) begin
      run_ticks <= run_ticks + 5'h01;
    end
  end

  sequence s_finish(logic [11:0] code);
    $fell(busy) && (instr_q == code);
  endsequence

  sequence s_accept;
    wr_acc && (paddr == OFS_INSTR) && !busy;
  endsequence

  AST_OPCLASS: assert property (s_accept |=> dec.operate_class ==
      ($past(pwdata[11:9]) == OPC_OPERATE)) else $error("operate class decode wrong");

  AST_GROUP: assert property (s_accept |=> (dec.grp2 == (dec.operate_class &&
      instr_q[GRP_BIT] && !instr_q[G23_BIT])) && (dec.grp1 == (dec.operate_class &&
      !instr_q[GRP_BIT]))) else $error("group select decode wrong");

  // A reset also drops busy, and that is no finish
  AST_RUNLEN: assert property ($fell(busy) && !$past(srst) |-> run_ticks ==
      (((instr_q & LONG_MASK) != 12'h000) ? STATES_LONG : STATES_SHORT))
      else $error("state count of instruction wrong");

  AST_START: assert property (start |=> busy && (fsm == FSM_STEP) && !done)
      else $error("start did not enter first step");

  AST_IDLE: assert property (s_finish(CODE_IDLE) |->
      acc.word == word_start && acc.flag == flag_start) else $error("idle changed state");

  AST_BUMP: assert property (s_finish(CODE_BUMP) |-> acc.word == word_start + 12'h001 &&
      acc.flag == (flag_start ^ (word_start == 12'hFFF))) else $error("bump result wrong");

  AST_ROTL1: assert property (s_finish(CODE_ROTL1) |->
      {acc.flag, acc.word} == {word_start, flag_start}) else $error("rotate left one wrong");

  AST_ROTR2: assert property (s_finish(CODE_ROTR2) |-> acc.flag == word_start[1] &&
      acc.word[10] == flag_start) else $error("rotate right two wrong");

  AST_SWAP: assert property (s_finish(CODE_SWAP) |-> acc.word ==
      {word_start[5:0], word_start[11:6]} && acc.flag == flag_start) else $error("swap wrong");

  AST_NEGATE: assert property (s_finish(CODE_NEGATE) |-> acc.word ==
      12'h000 - word_start) else $error("negate result wrong");

  AST_SETFLAG: assert property (s_finish(CODE_SETFLAG) |-> acc.flag == 1'b1)
      else $error("set flag did not end at one");

  AST_FETCH: assert property (s_finish(CODE_FETCH) |-> acc.flag == 1'b0 &&
      acc.word == {11'h000, flag_start}) else $error("fetch flag wrong");

  AST_ONES: assert property (s_finish(CODE_ONES) |-> acc.word == 12'hFFF)
      else $error("all ones wrong");

  AST_ZBOTH: assert property (s_finish(CODE_ZBOTH) |-> acc.word == 12'h000 &&
      !acc.flag) else $error("same-step clears wrong");

  AST_BUSYHOLD: assert property (start |=> busy [*4])
      else $error("busy dropped during steps");

  // Remaining operation results, the negate carry and the group-three decode
  AST_ROTL2: assert property (s_finish(CODE_ROTL2) |-> acc.flag == word_start[10] &&
      acc.word[1] == flag_start) else $error("rotate left two wrong");

  AST_ROTR1: assert property (s_finish(CODE_ROTR1) |-> {acc.flag, acc.word} ==
      {word_start[0], flag_start, word_start[11:1]}) else $error("rotate right one wrong");

  AST_INVFLAG: assert property (s_finish(CODE_INVFLAG) |-> acc.flag == !flag_start &&
      acc.word == word_start) else $error("invert flag wrong");

  AST_INVWORD: assert property (s_finish(CODE_INVWORD) |-> acc.word == ~word_start &&
      acc.flag == flag_start) else $error("invert word wrong");

  AST_ZFLAG: assert property (s_finish(CODE_ZFLAG) |-> !acc.flag &&
      acc.word == word_start) else $error("zero flag wrong");

  AST_ZWORD: assert property (s_finish(CODE_ZWORD) |-> acc.word == 12'h000 &&
      acc.flag == flag_start) else $error("zero word wrong");

  AST_NEGFLAG: assert property (s_finish(CODE_NEGATE) |-> acc.flag ==
      (flag_start ^ (word_start == 12'h000))) else $error("negate carry wrong");

  AST_GRP3: assert property (s_accept |=> dec.grp3 ==
      (($past(pwdata[11:8]) == 4'hF) && $past(pwdata[G23_BIT])))
      else $error("group three decode wrong");

  // Group two and three are decoded only; they never start a run
  AST_NOSTART: assert property (wr_acc && (paddr == OFS_INSTR) && !busy &&
      pwdata[GRP_BIT] |=> !busy) else $error("non group-one instruction started");

  // Port copies lag the internal state by one cycle, except just after reset
  AST_PORTCOPY: assert property (!$past(srst) |-> work_register == $past(acc.word) &&
      carry_flag == $past(acc.flag)) else $error("port copy of state wrong");

endmodule // ocg_operate_unit

// *** pkg/ocg_pkg.sv ***
// Constants, types and decode helper for the operate group-one unit
package ocg_pkg;

  // Word and instruction layout (vector index = 11 - documented bit number)
  localparam int          WORD_W        = 12;
  localparam int          OPC_MSB       = 11;
  localparam int          OPC_LSB       = 9;
  localparam logic [2:0]  OPC_OPERATE   = 3'h7;
  localparam int          GRP_BIT       = 8;
  localparam int          G23_BIT       = 0;

  // Group-one select bits
  localparam int          SEL_ZERO_WORD = 7;
  localparam int          SEL_ZERO_FLAG = 6;
  localparam int          SEL_INV_WORD  = 5;
  localparam int          SEL_INV_FLAG  = 4;
  localparam int          SEL_ROT_R     = 3;
  localparam int          SEL_ROT_L     = 2;
  localparam int          SEL_DOUBLE    = 1;
  localparam int          SEL_BUMP      = 0;
  localparam logic [11:0] LONG_MASK     = 12'h00E;

  // Sequence steps and state counts
  localparam int          CNT_W         = 5;
  localparam logic [1:0]  SEQ_FIRST     = 2'h0;
  localparam logic [1:0]  SEQ_SECOND    = 2'h1;
  localparam logic [1:0]  SEQ_THIRD     = 2'h2;
  localparam logic [1:0]  SEQ_LAST      = 2'h3;
  localparam logic [4:0]  STATES_SHORT  = 5'h0A;
  localparam logic [4:0]  STATES_LONG   = 5'h0F;
  localparam int          STATE_DIV     = 1;

  // Register map, byte addresses
  localparam int          APB_AW        = 8;
  localparam logic [7:0]  OFS_INSTR     = 8'h00;
  localparam logic [7:0]  OFS_WORK      = 8'h04;
  localparam logic [7:0]  OFS_FLAG      = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam logic [7:0]  OFS_STATES    = 8'h10;

  // Status fields
  localparam int          STB_BUSY      = 0;
  localparam int          STB_DONE      = 1;
  localparam int          STB_OPCLASS   = 2;
  localparam int          STB_G1        = 3;
  localparam int          STB_G2        = 4;
  localparam int          STB_G3        = 5;
  localparam int          STB_REFUSED   = 6;

  // Reset values
  localparam logic [11:0] RST_WORD      = 12'h000;
  localparam logic        RST_FLAG      = 1'b0;
  localparam logic [11:0] RST_INSTR     = 12'h000;

  // Instruction codes
  localparam logic [11:0] CODE_IDLE     = 12'hE00;
  localparam logic [11:0] CODE_BUMP     = 12'hE01;
  localparam logic [11:0] CODE_SWAP     = 12'hE02;
  localparam logic [11:0] CODE_ROTL1    = 12'hE04;
  localparam logic [11:0] CODE_ROTL2    = 12'hE06;
  localparam logic [11:0] CODE_ROTR1    = 12'hE08;
  localparam logic [11:0] CODE_ROTR2    = 12'hE0A;
  localparam logic [11:0] CODE_INVFLAG  = 12'hE10;
  localparam logic [11:0] CODE_INVWORD  = 12'hE20;
  localparam logic [11:0] CODE_NEGATE   = 12'hE21;
  localparam logic [11:0] CODE_ZFLAG    = 12'hE40;
  localparam logic [11:0] CODE_SETFLAG  = 12'hE50;
  localparam logic [11:0] CODE_ZWORD    = 12'hE80;
  localparam logic [11:0] CODE_FETCH    = 12'hE84;
  localparam logic [11:0] CODE_ONES     = 12'hEA0;
  localparam logic [11:0] CODE_ZBOTH    = 12'hEC0;

  typedef struct packed {
    logic        flag;
    logic [11:0] word;
  } ocg_acc_s;

  typedef struct packed {
    logic operate_class;
    logic grp1;
    logic grp2;
    logic grp3;
  } ocg_dec_s;

  typedef enum logic [2:0] {
    FSM_IDLE = 3'b001,
    FSM_STEP = 3'b010,
    FSM_HOLD = 3'b100
  } ocg_fsm_e;

  function automatic ocg_dec_s ocg_decode(input logic [11:0] ins);
    ocg_dec_s d;
    d.operate_class = (ins[OPC_MSB:OPC_LSB] == OPC_OPERATE);
    d.grp1          = d.operate_class & ~ins[GRP_BIT];
    d.grp2          = d.operate_class & ins[GRP_BIT] & ~ins[G23_BIT];
    d.grp3          = d.operate_class & ins[GRP_BIT] & ins[G23_BIT];
    return d;
  endfunction

endpackage

// *** hw/ocg_tick_div.sv ***
// State-rate enable divider
`timescale 1ns/100ps
module ocg_tick_div
  import ocg_pkg::*;
#(
  parameter int DIV = STATE_DIV
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Control
  input  wire logic clr,
  output logic      tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt;

  // Restart on clear so each instruction sees whole states
  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      cnt <= '0;
    end else if (cnt == CW'(DIV - 1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  assign tick = (cnt == CW'(DIV - 1));
endmodule // ocg_tick_div

// *** hw/ocg_g1_step.sv ***
// One logical-sequence step of a group-one microinstruction
`timescale 1ns/100ps
module ocg_g1_step
  import ocg_pkg::*;
(
  // Step selection
  input  wire logic [7:0] sel,
  input  wire logic [1:0] step,
  // Data
  input  ocg_acc_s        acc_in,
  output ocg_acc_s        acc_out
);
  logic [12:0] rot;
  logic        carry;
  logic [11:0] sum;

  always_comb begin
    acc_out = acc_in;
    rot     = {acc_in.flag, acc_in.word};
    {carry, sum} = {1'b0, acc_in.word} + 13'h0001;
    case (step)
      SEQ_FIRST: begin
        if (sel[SEL_ZERO_WORD]) acc_out.word = '0;
        if (sel[SEL_ZERO_FLAG]) acc_out.flag = 1'b0;
      end
      SEQ_SECOND: begin
        if (sel[SEL_INV_WORD]) acc_out.word = ~acc_in.word;
        if (sel[SEL_INV_FLAG]) acc_out.flag = ~acc_in.flag;
      end
      SEQ_THIRD: begin
        if (sel[SEL_BUMP]) begin
          acc_out.word = sum;
          acc_out.flag = acc_in.flag ^ carry;
        end
      end
      SEQ_LAST: begin
        // Both rotate directions at once conflict and are left as no-op
        if (sel[SEL_ROT_L] && !sel[SEL_ROT_R]) begin
          if (sel[SEL_DOUBLE]) {acc_out.flag, acc_out.word} = {rot[10:0], rot[12:11]};
          else {acc_out.flag, acc_out.word} = {rot[11:0], rot[12]};
        end else if (sel[SEL_ROT_R] && !sel[SEL_ROT_L]) begin
          if (sel[SEL_DOUBLE]) {acc_out.flag, acc_out.word} = {rot[1:0], rot[12:2]};
          else {acc_out.flag, acc_out.word} = {rot[0], rot[12:1]};
        end else if (sel[SEL_DOUBLE] && !sel[SEL_ROT_L] && !sel[SEL_ROT_R]) begin
          acc_out.word = {acc_in.word[5:0], acc_in.word[11:6]};
        end
      end
      default: acc_out = acc_in;
    endcase
  end
endmodule // ocg_g1_step

// *** bench/tb.sv ***
// Self-checking testbench for the operate group-one unit
`timescale 1ns/100ps
module tb;
  import ocg_pkg::*;

  localparam int          DIVP  = 2;
  localparam int          NCODE = 23;
  localparam logic [11:0] CODES [NCODE] = '{CODE_IDLE, CODE_BUMP, CODE_SWAP, CODE_ROTL1,
    CODE_ROTL2, CODE_ROTR1, CODE_ROTR2, CODE_INVFLAG, CODE_INVWORD, CODE_NEGATE, CODE_ZFLAG,
    CODE_SETFLAG, CODE_ZWORD, CODE_FETCH, CODE_ONES, CODE_ZBOTH, 12'hE05, 12'hEA1,
    12'hE88, 12'hE61, 12'hE11, 12'hE4A, 12'hE0C};

  logic              mclk    = 1'b0;
  logic              srst    = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [APB_AW-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [11:0]       work_register;
  logic              carry_flag;
  logic              busy;
  logic [31:0]       rq;
  logic              re;
  int                err_total   = 0;
  int                check_count = 0;

  always #5 mclk = ~mclk;

  ocg_operate_unit #(.DIV(DIVP)) u_ocg_operate_unit (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .work_register(work_register), .carry_flag(carry_flag), .busy(busy)
  );

  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // Every transfer opens one edge late so no signal is driven twice per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      err_total++;
      print_verdict();
    end
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle(output int n);
    int k;
    n = 0;
    for (k = 0; k < 200; k++) begin
      @(posedge mclk);
      if (busy !== 1'b1) break;
      n++;
    end
    if (k == 200) begin
      err_total++;
      print_verdict();
    end
  endtask

  // Reference behaviour: sequence 1 to 4 in order, same-sequence parts together
  function automatic logic [12:0] expect_g1(input logic [11:0] c, input logic [11:0] w0,
                                            input logic f0);
    logic [11:0] w;
    logic        f;
    logic        cy;
    w = w0;
    f = f0;
    if (c[SEL_ZERO_WORD]) w = 12'h000;
    if (c[SEL_ZERO_FLAG]) f = 1'b0;
    if (c[SEL_INV_WORD]) w = ~w;
    if (c[SEL_INV_FLAG]) f = ~f;
    if (c[SEL_BUMP]) begin
      {cy, w} = {1'b0, w} + 13'h0001;
      f = f ^ cy;
    end
    case (c[3:1])
      3'b010: {f, w} = {w, f};
      3'b011: {f, w} = {w[10:0], f, w[11]};
      3'b100: {f, w} = {w[0], f, w[11:1]};
      3'b101: {f, w} = {w[1], w[0], f, w[11:2]};
      3'b001: w = {w[5:0], w[11:6]};
      default: ;
    endcase
    return {f, w};
  endfunction

  task automatic run_op(input logic [11:0] c, input logic [11:0] w0, input logic f0);
    logic [12:0] e;
    int          n;
    e = expect_g1(c, w0, f0);
    apb(1'b1, OFS_WORK, {20'h0, w0});
    apb(1'b1, OFS_FLAG, {31'h0, f0});
    apb(1'b1, OFS_INSTR, {20'h0, c});
    wait_idle(n);
    chk("busy cycles", 32'((c[3:1] != 3'h0 ? 15 : 10) * DIVP), n);
    apb(1'b0, OFS_WORK, 32'h0);
    chk("work", {20'h0, e[11:0]}, rq);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk("flag", {31'h0, e[12]}, rq);
    apb(1'b0, OFS_STATES, 32'h0);
    chk("states", (c[3:1] != 3'h0) ? 32'h0F : 32'h0A, rq);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h0E, rq);
    chk("work port", {20'h0, e[11:0]}, {20'h0, work_register});
    chk("flag port", {31'h0, e[12]}, {31'h0, carry_flag});
  endtask

  task automatic t_reset();
    apb(1'b0, OFS_INSTR, 32'h0);
    chk("instr reset", 32'h0, rq);
    apb(1'b0, OFS_WORK, 32'h0);
    chk("work reset", 32'h0, rq);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk("flag reset", 32'h0, rq);
    apb(1'b0, OFS_STATES, 32'h0);
    chk("states reset", 32'h0A, rq);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", 32'h0, rq);
    chk("slverr reset", 32'h0, {31'h0, re});
  endtask

  // Each code twice: a mixed word, then all ones so bumps carry out
  task automatic t_codes();
    for (int i = 0; i < NCODE; i++) begin
      run_op(CODES[i], 12'hA5C, 1'b0);
      run_op(CODES[i], 12'hFFF, 1'b1);
    end
    run_op(CODE_NEGATE, 12'h000, 1'b1);
  endtask

  task automatic t_groups();
    logic [11:0] gc [3];
    logic [31:0] gs [3];
    gc = '{12'hF00, 12'hF01, 12'h200};
    gs = '{32'h14, 32'h24, 32'h00};
    apb(1'b1, OFS_WORK, 32'h123);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_INSTR, {20'h0, gc[i]});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("group status", gs[i], rq & 32'hFD);
      apb(1'b0, OFS_WORK, 32'h0);
      chk("word kept", 32'h123, rq);
    end
  endtask

  task automatic t_refuse();
    int n;
    apb(1'b1, OFS_WORK, 32'h123);
    apb(1'b1, OFS_INSTR, {20'h0, CODE_INVWORD});
    apb(1'b1, OFS_WORK, 32'h456);
    wait_idle(n);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("refused", 32'h40, rq & 32'h40);
    apb(1'b0, OFS_WORK, 32'h0);
    chk("work busy write", 32'hEDC, rq);
    run_op(CODE_SETFLAG, 12'h000, 1'b0);
  endtask

  task automatic t_unmapped();
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped read data", 32'h0, rq);
    chk("unmapped read err", 32'h1, {31'h0, re});
    apb(1'b1, 8'h18, 32'hFFF);
    chk("unmapped write err", 32'h1, {31'h0, re});
    apb(1'b0, OFS_WORK, 32'h0);
    chk("work after unmapped", 32'h0, rq & 32'hFFF);
  endtask

  // Reset while busy must abandon the run and restore every reset value
  task automatic t_midreset();
    apb(1'b1, OFS_WORK, 32'h5A5);
    apb(1'b1, OFS_INSTR, {20'h0, CODE_ROTL1});
    repeat (3) @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    chk("busy after reset", 32'h0, {31'h0, busy});
    chk("work port after reset", 32'h0, {20'h0, work_register});
    t_reset();
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_codes();
    t_groups();
    t_refuse();
    t_unmapped();
    t_midreset();
    print_verdict();
  end

endmodule // tb
